/* File: rtl/ipms_regs.vh */
// constants for the init and power mode sequencer
// assumes a 250 MHz core clock; register offsets are byte addresses on apb
// Notes on behaviour
// - restart low over 10 us requests warm start
// - warm start runs from zero after pin release
// - cold start waits for oscillator, then zero
// - warm start keeps flags, ram, timers
// - both starts clear pc, digits, supply, stack
// - warm start mid-write may corrupt that word
// - signature a5 found: keep ram, warm
// - signature missing: clear ram, cold
// - timers run through warm start until stopped
// - four modes: off, done, active, converting
// - off keeps ram, pins and port lines only
// - off entered by software, left by wake/init
// - port wake rule on held prior levels
// - done keeps ram, outputs, display, timekeeping
// - done left by port, init or timer tick
// - converter powered only while converting
// - crystal timers give 1 hz and 16 hz
// - sensor supply on only during conversion
`ifndef IPMS_REGS_VH
`define IPMS_REGS_VH
`define IPMS_CLK_MHZ        250
`define IPMS_RESTART_NS     10000
// restart_ns at clk_mhz, plus one cycle so the hold must exceed the full time
`define IPMS_RESTART_CYC    16'h09C5
`define IPMS_SIG_VALUE      8'hA5
`define IPMS_RAM_WORDS      16
`define IPMS_SIG_LO_IDX     4'hE
`define IPMS_SIG_HI_IDX     4'hF
`define IPMS_OFS_CTRL       12'h000
`define IPMS_OFS_STATUS     12'h004
`define IPMS_OFS_RAM        12'h040
`define IPMS_OFS_LATCH      12'h008
`define IPMS_CTRL_CMD_OFF   0
`define IPMS_CTRL_CMD_DONE  1
`define IPMS_CTRL_CONV_GO   2
`define IPMS_CTRL_CONV_END  3
`define IPMS_CTRL_STOP_TMR  4
`define IPMS_CTRL_WAKE_1HZ  5
`define IPMS_CTRL_WAKE_16HZ 6
`endif

/* File: rtl/ipms_sequencer.v */
// init and power mode sequencer: start type, ram signature, mode control
// assumes crystal timer ticks and port lines arrive from outside this clock domain
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ipms_regs.vh"
module ipms_sequencer (
    input  wire        i_clk,
    input  wire        i_rst_n,
    input  wire        i_por_n,
    input  wire        i_osc_ready,
    input  wire        i_restart_request_n,
    input  wire [3:0]  i_wake_port,
    input  wire        i_tick_1hz,
    input  wire        i_tick_16hz,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    output reg  [1:0]  o_mode,
    output reg         o_cpu_run,
    output reg  [11:0] o_program_counter,
    output reg  [1:0]  o_stack_level,
    output reg  [15:0] o_digit_latch_bank,
    output reg         o_sensor_supply_switch,
    output reg         o_adc_power,
    output reg         o_timers_run,
    output reg         o_core_power,
    output reg         o_cold_start
);
    // ************************************************************
    // modes and init states
    // ************************************************************
    localparam [1:0] M_OFF   = 2'h0;
    localparam [1:0] M_DONE  = 2'h1;
    localparam [1:0] M_ACT   = 2'h2;
    localparam [1:0] M_CONV  = 2'h3;
    localparam [2:0] S_POR   = 3'h0;
    localparam [2:0] S_HOLD  = 3'h1;
    localparam [2:0] S_CHECK = 3'h2;
    localparam [2:0] S_CLEAR = 3'h3;
    localparam [2:0] S_RUN   = 3'h4;
    // the count is one past the full hold time, so exactly 10 us is not enough
    localparam [15:0] CNT_MAX = `IPMS_RESTART_CYC;

    // ************************************************************
    // synchronisers
    // ************************************************************
    // no reset here: hold power-up reset long enough to flush both stages
    reg [7:0] meta_reg;
    reg [7:0] sync_reg;
    always @(posedge i_clk) begin
        meta_reg <= {i_osc_ready, i_restart_request_n, i_tick_16hz, i_tick_1hz, i_wake_port};
        sync_reg <= meta_reg;
    end
    wire [3:0] port_s   = sync_reg[3:0];
    wire       t1_s     = sync_reg[4];
    wire       t16_s    = sync_reg[5];
    wire       rst_in_s = sync_reg[6];
    wire       osc_s    = sync_reg[7];
    reg        t1_d_reg;
    reg        t16_d_reg;
    always @(posedge i_clk) begin
        t1_d_reg  <= t1_s;
        t16_d_reg <= t16_s;
    end
    wire tick1  = t1_s & ~t1_d_reg;
    wire tick16 = t16_s & ~t16_d_reg;

    // ************************************************************
    // state
    // ************************************************************
    reg [2:0]  state_reg;
    reg [15:0] low_cnt_reg;
    reg        armed_reg;
    reg [3:0]  held_port_reg;
    reg [3:0]  clr_idx_reg;
    reg [7:0]  ram_reg [0:`IPMS_RAM_WORDS-1];
    reg        wake_1hz_en_reg;
    reg        wake_16hz_en_reg;

    // ************************************************************
    // restart qualification
    // ************************************************************
    // restart pin must stay low past the full time before a request is armed
    always @(posedge i_clk) begin
        if (!i_rst_n || rst_in_s) begin
            low_cnt_reg <= 16'h0000;
        end else if (low_cnt_reg != CNT_MAX) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end
    end
    wire restart_long = (low_cnt_reg == CNT_MAX);

    // ************************************************************
    // wake sources
    // ************************************************************
    // wake evaluated against levels captured at low-power entry
    // other held patterns cannot wake on the port, only init or, in done mode, a tick
    wire wake_port = (held_port_reg == 4'h0) ? (port_s != 4'h0) :
                     (held_port_reg == 4'h8) ? ((~port_s[3]) | (port_s[2:0] != 3'h0)) :
                     1'b0;
    wire wake_tmr = (wake_1hz_en_reg & tick1) | (wake_16hz_en_reg & tick16);

    // signature nibbles sit in the two top words, which software must keep
    wire sig_ok = {ram_reg[`IPMS_SIG_HI_IDX][3:0], ram_reg[`IPMS_SIG_LO_IDX][3:0]}
                  == `IPMS_SIG_VALUE;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire bus_wr = i_psel & i_penable & i_pwrite & o_pready;
    wire bus_rd = i_psel & ~i_penable & ~i_pwrite;
    wire ram_hit = (i_paddr >= `IPMS_OFS_RAM) &&
                   (i_paddr < `IPMS_OFS_RAM + 12'h040) && (i_paddr[1:0] == 2'b00);
    wire [3:0] ram_idx = i_paddr[5:2];
    wire ctrl_wr = bus_wr && (i_paddr == `IPMS_OFS_CTRL) && o_cpu_run;

    // ************************************************************
    // ram storage: only clearing touches it outside cpu writes
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < `IPMS_RAM_WORDS; g = g + 1) begin : g_ram
            always @(posedge i_clk) begin
                if (!i_por_n) begin
                    ram_reg[g] <= 8'h00;
                end else if (state_reg == S_CLEAR && clr_idx_reg == g) begin
                    ram_reg[g] <= 8'h00;
                end else if (bus_wr && ram_hit && ram_idx == g && o_cpu_run) begin
                    ram_reg[g] <= i_pwdata[7:0];
                end
            end
        end
    endgenerate

    // ************************************************************
    // start and mode sequencing
    // ************************************************************
    always @(posedge i_clk) begin
        if (!i_por_n) begin
            state_reg              <= S_POR;
            armed_reg              <= 1'b0;
            o_mode                 <= M_ACT;
            o_cpu_run              <= 1'b0;
            o_program_counter      <= 12'h000;
            o_stack_level          <= 2'd0;
            o_digit_latch_bank     <= 16'h0000;
            o_sensor_supply_switch <= 1'b0;
            o_adc_power            <= 1'b0;
            o_timers_run           <= 1'b0;
            o_core_power           <= 1'b1;
            o_cold_start           <= 1'b1;
            held_port_reg          <= 4'h0;
            clr_idx_reg            <= 4'h0;
            wake_1hz_en_reg        <= 1'b0;
            wake_16hz_en_reg       <= 1'b0;
        end else begin
            // arm only while running, or a still-held pin re-arms on the way out of hold
            if (restart_long && state_reg == S_RUN) begin
                armed_reg <= 1'b1;
            end
            case (state_reg)
            S_POR: begin
                if (osc_s) begin
                    state_reg <= S_CHECK;
                end
            end
            S_HOLD: begin
                if (rst_in_s) begin
                    state_reg <= S_CHECK;
                end
            end
            S_CHECK: begin
                if (sig_ok) begin
                    o_cold_start <= 1'b0;
                    state_reg    <= S_RUN;
                    o_cpu_run    <= 1'b1;
                end else begin
                    o_cold_start <= 1'b1;
                    clr_idx_reg  <= 4'h0;
                    state_reg    <= S_CLEAR;
                end
            end
            // one word a cycle: a cold start costs sixteen extra cycles
            S_CLEAR: begin
                clr_idx_reg <= clr_idx_reg + 4'h1;
                if (clr_idx_reg == 4'hF) begin
                    state_reg    <= S_RUN;
                    o_cpu_run    <= 1'b1;
                    o_timers_run <= 1'b0;
                end
            end
            default: begin
                if (armed_reg) begin
                    // warm start: flags, ram and timers left alone
                    // a conversion cut short by a restart is abandoned, not resumed
                    armed_reg              <= 1'b0;
                    state_reg              <= S_HOLD;
                    o_cpu_run              <= 1'b0;
                    o_mode                 <= M_ACT;
                    o_core_power           <= 1'b1;
                    o_program_counter      <= 12'h000;
                    o_stack_level          <= 2'd0;
                    o_digit_latch_bank     <= 16'h0000;
                    o_sensor_supply_switch <= 1'b0;
                    o_adc_power            <= 1'b0;
                end else begin
                    case (o_mode)
                    M_OFF: begin
                        if (wake_port) begin
                            o_mode       <= M_ACT;
                            o_cpu_run    <= 1'b1;
                            o_core_power <= 1'b1;
                        end
                    end
                    M_DONE: begin
                        if (wake_port || wake_tmr) begin
                            o_mode    <= M_ACT;
                            o_cpu_run <= 1'b1;
                        end
                    end
                    M_CONV: begin
                        if (ctrl_wr && i_pwdata[`IPMS_CTRL_CONV_END]) begin
                            o_mode                 <= M_ACT;
                            o_sensor_supply_switch <= 1'b0;
                            o_adc_power            <= 1'b0;
                        end
                    end
                    default: begin
                        if (ctrl_wr) begin
                            if (i_pwdata[`IPMS_CTRL_STOP_TMR]) begin
                                o_timers_run <= 1'b0;
                            end else begin
                                o_timers_run <= 1'b1;
                            end
                            wake_1hz_en_reg  <= i_pwdata[`IPMS_CTRL_WAKE_1HZ];
                            wake_16hz_en_reg <= i_pwdata[`IPMS_CTRL_WAKE_16HZ];
                            if (i_pwdata[`IPMS_CTRL_CMD_OFF]) begin
                                o_mode        <= M_OFF;
                                o_cpu_run     <= 1'b0;
                                o_core_power  <= 1'b0;
                                o_timers_run  <= 1'b0;
                                held_port_reg <= port_s;
                            end else if (i_pwdata[`IPMS_CTRL_CMD_DONE]) begin
                                o_mode        <= M_DONE;
                                o_cpu_run     <= 1'b0;
                                held_port_reg <= port_s;
                            end else if (i_pwdata[`IPMS_CTRL_CONV_GO]) begin
                                o_mode                 <= M_CONV;
                                o_sensor_supply_switch <= 1'b1;
                                o_adc_power            <= 1'b1;
                            end
                        end else if (bus_wr && i_paddr == `IPMS_OFS_LATCH) begin
                            o_digit_latch_bank <= i_pwdata[15:0];
                        end
                        // stand-in for instruction fetch; a bus write stalls it one cycle
                        if (o_cpu_run && !bus_wr) begin
                            o_program_counter <= o_program_counter + 12'h001;
                        end
                    end
                    endcase
                end
            end
            endcase
        end
    end

    // ************************************************************
    // apb slave: no wait states, reads prepared in setup
    // ************************************************************
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= 1'b0;
            if (i_psel && !i_penable) begin
                o_pslverr <= ~(ram_hit || i_paddr == `IPMS_OFS_CTRL ||
                               i_paddr == `IPMS_OFS_STATUS || i_paddr == `IPMS_OFS_LATCH);
            end
            // read data is captured at setup, so it stands through the access
            if (bus_rd) begin
                if (ram_hit) begin
                    o_prdata <= {24'h00_0000, ram_reg[ram_idx]};
                end else if (i_paddr == `IPMS_OFS_STATUS) begin
                    o_prdata <= {16'h0000, 1'b0, state_reg, held_port_reg, o_cold_start,
                                 o_cpu_run, o_timers_run, wake_16hz_en_reg, wake_1hz_en_reg,
                                 o_adc_power, o_mode};
                end else if (i_paddr == `IPMS_OFS_LATCH) begin
                    o_prdata <= {16'h0000, o_digit_latch_bank};
                end else begin
                    o_prdata <= 32'h0000_0000;
                end
            end
        end
    end
endmodule // ipms_sequencer
`default_nettype wire

/* File: dv/ipms_seq_checker.sv */
// assertions for the init and power mode sequencer
// assumes binding onto the ports of ipms_sequencer
`timescale 1ns/10ps
`default_nettype none
module ipms_seq_checker (
    input wire logic        i_clk,
    input wire logic        i_por_n,
    input wire logic        i_restart_request_n,
    input wire logic [1:0]  o_mode,
    input wire logic        o_cpu_run,
    input wire logic [1:0]  o_stack_level,
    input wire logic [15:0] o_digit_latch_bank,
    input wire logic        o_sensor_supply_switch,
    input wire logic        o_adc_power,
    input wire logic        o_core_power
);
    // ****
    // restart hold length
    // ****
    logic [11:0] low_cnt_reg;
    // saturates so a very long hold still counts as long
    always_ff @(posedge i_clk) begin
        if (!i_por_n || i_restart_request_n) low_cnt_reg <= 12'h000;
        else if (low_cnt_reg != 12'hFFF) low_cnt_reg <= low_cnt_reg + 12'h001;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_por_n);
    // margin covers the two synchroniser stages and the apply edge
    sequence s_long_low;
        low_cnt_reg >= 12'h9D8;
    endsequence
    supply_tracks_mode_a : assert property (
        o_sensor_supply_switch == (o_mode == 2'h3)) else $error("supply out of step with mode");
    adc_tracks_mode_a : assert property (
        o_adc_power == (o_mode == 2'h3)) else $error("converter power out of step with mode");
    run_needs_active_a : assert property (
        o_cpu_run |-> o_mode[1]) else $error("cpu running outside active mode");
    core_off_mode_a : assert property (
        o_core_power == (o_mode != 2'h0)) else $error("core power wrong for mode");
    restart_stops_a : assert property (
        s_long_low |-> !o_cpu_run) else $error("cpu runs while restart held");
    restart_clears_a : assert property (
        s_long_low |-> (o_digit_latch_bank == 16'h0000 && o_stack_level == 2'h0
            && !o_sensor_supply_switch)) else $error("restart left state uncleared");
    restart_resumes_a : assert property (
        ($rose(i_restart_request_n) && low_cnt_reg >= 12'h9D8) |-> ##[1:40] o_cpu_run)
        else $error("cpu did not resume after restart release");
    conv_from_active_a : assert property (
        $rose(o_sensor_supply_switch) |-> $past(o_mode) == 2'h2)
        else $error("conversion entered from a low power mode");
endmodule // ipms_seq_checker
bind ipms_sequencer ipms_seq_checker i_chk (.i_clk(i_clk), .i_por_n(i_por_n),
    .i_restart_request_n(i_restart_request_n), .o_mode(o_mode), .o_cpu_run(o_cpu_run),
    .o_stack_level(o_stack_level), .o_digit_latch_bank(o_digit_latch_bank),
    .o_sensor_supply_switch(o_sensor_supply_switch), .o_adc_power(o_adc_power),
    .o_core_power(o_core_power));
`default_nettype wire

/* File: dv/ipms_port_model.sv */
// restart pin and wake port lines seen from outside the device
// assumes the bench calls its tasks; changes land just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module ipms_port_model (
    input  wire logic  i_clk,
    output logic       o_restart_request_n,
    output logic [3:0] o_wake_port
);
    initial begin
        o_restart_request_n = 1'h1;
        o_wake_port         = 4'h0;
    end
    // pin idles high, so release returns it to the pulled-up level
    task automatic restart(input int unsigned cyc);
        @(posedge i_clk) o_restart_request_n <= 1'h0;
        repeat (cyc) @(posedge i_clk);
        o_restart_request_n <= 1'h1;
    endtask
    task automatic set_port(input logic [3:0] lv);
        @(posedge i_clk) o_wake_port <= lv;
    endtask
endmodule // ipms_port_model
`default_nettype wire

/* File: dv/ipms_sequencer_tb.sv */
// self-checking bench for the init and power mode sequencer
// assumes apb slave, port model and bound checker
`timescale 1ns/10ps
`default_nettype none
module ipms_sequencer_tb;
    logic        i_clk, i_rst_n, i_por_n, i_osc_ready, i_tick_1hz, i_tick_16hz;
    logic        i_psel, i_penable, i_pwrite, o_pready, o_pslverr, slv_err;
    logic        o_cpu_run, o_sensor_supply_switch, o_adc_power, o_timers_run;
    logic        o_core_power, o_cold_start;
    logic [11:0] i_paddr, o_program_counter;
    logic [31:0] i_pwdata, o_prdata, rd_val;
    logic [1:0]  o_mode, o_stack_level;
    logic [15:0] o_digit_latch_bank;
    wire logic   restart_n;
    wire logic [3:0] wake_port;
    int          err_count, checks_done;
    ipms_port_model i_prt (.i_clk(i_clk), .o_restart_request_n(restart_n),
        .o_wake_port(wake_port));
    ipms_sequencer i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n),
        .i_osc_ready(i_osc_ready), .i_restart_request_n(restart_n), .i_wake_port(wake_port),
        .i_tick_1hz(i_tick_1hz), .i_tick_16hz(i_tick_16hz), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mode(o_mode),
        .o_cpu_run(o_cpu_run), .o_program_counter(o_program_counter),
        .o_stack_level(o_stack_level), .o_digit_latch_bank(o_digit_latch_bank),
        .o_sensor_supply_switch(o_sensor_supply_switch), .o_adc_power(o_adc_power),
        .o_timers_run(o_timers_run), .o_core_power(o_core_power),
        .o_cold_start(o_cold_start));
    // ****
    // shared tasks
    // ****
    task automatic close_out;
        if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // request stands until pready is seen high at a rising edge; data is taken there
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_penable <= 1'h0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        do begin @(posedge i_clk); n++; end while (o_pready !== 1'h1 && n < 50);
        if (o_pready !== 1'h1) begin err_count++; close_out(); end
        rd_val = o_prdata;
        slv_err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask
    task automatic wait_run(input int lim);
        int n;
        n = 0;
        while (o_cpu_run !== 1'h1 && n < lim) begin @(negedge i_clk); n++; end
        if (o_cpu_run !== 1'h1) begin err_count++; close_out(); end
    endtask
    // ****
    // scenarios
    // ****
    task automatic sc_cold;
        idle(20);
        chk(o_cpu_run, 1'h0);
        @(posedge i_clk) i_osc_ready <= 1'h1;
        wait_run(100);
        chk(o_program_counter < 12'h004, 1'h1);
        chk({o_cold_start, o_mode, o_stack_level, o_digit_latch_bank, o_sensor_supply_switch},
            {1'h1, 2'h2, 2'h0, 16'h0000, 1'h0});
        apb(1'h0, 12'h078, 32'h0000_0000);
        chk(rd_val, 32'h0000_0000);
    endtask
    task automatic sc_warm;
        apb(1'h1, 12'h008, 32'h0000_1234);
        apb(1'h1, 12'h078, 32'h0000_0005);
        apb(1'h1, 12'h07C, 32'h0000_000A);
        apb(1'h1, 12'h04C, 32'h0000_003C);
        apb(1'h1, 12'h000, 32'h0000_0000);
        chk(o_digit_latch_bank, 16'h1234);
        i_prt.restart(100);
        idle(8);
        chk(o_cpu_run, 1'h1);
        i_prt.restart(2600);
        wait_run(100);
        chk({o_digit_latch_bank, o_cold_start, o_timers_run}, 18'h0_0001);
        apb(1'h0, 12'h04C, 32'h0000_0000);
        chk(rd_val, 32'h0000_003C);
    endtask
    task automatic sc_modes;
        apb(1'h1, 12'h000, 32'h0000_0002);
        idle(6);
        chk(o_mode, 2'h1);
        i_prt.set_port(4'h2);
        idle(8);
        chk(o_mode, 2'h2);
        i_prt.set_port(4'h8);
        apb(1'h1, 12'h000, 32'h0000_0001);
        idle(6);
        chk({o_mode, o_core_power}, 3'h0);
        i_prt.set_port(4'h0);
        idle(8);
        chk(o_mode, 2'h2);
        i_prt.set_port(4'h3);
        apb(1'h1, 12'h000, 32'h0000_0001);
        i_prt.set_port(4'h1);
        idle(8);
        chk(o_mode, 2'h0);
        i_prt.restart(2600);
        wait_run(100);
        chk(o_mode, 2'h2);
        apb(1'h1, 12'h000, 32'h0000_0022);
        idle(6);
        chk(o_mode, 2'h1);
        @(posedge i_clk) i_tick_1hz <= 1'h1;
        idle(8);
        chk(o_mode, 2'h2);
        @(posedge i_clk) i_tick_1hz <= 1'h0;
    endtask
    task automatic sc_timers;
        apb(1'h1, 12'h000, 32'h0000_0042);
        idle(6);
        chk(o_mode, 2'h1);
        @(posedge i_clk) i_tick_1hz <= 1'h1;
        idle(8);
        chk(o_mode, 2'h1);
        @(posedge i_clk) i_tick_1hz <= 1'h0;
        i_tick_16hz <= 1'h1;
        idle(8);
        chk(o_mode, 2'h2);
        @(posedge i_clk) i_tick_16hz <= 1'h0;
        chk(o_timers_run, 1'h1);
        apb(1'h1, 12'h000, 32'h0000_0010);
        idle(4);
        chk(o_timers_run, 1'h0);
    endtask
    task automatic sc_reset;
        apb(1'h0, 12'h04C, 32'h0000_0000);
        chk(rd_val, 32'h0000_003C);
        @(posedge i_clk);
        i_rst_n <= 1'h0;
        i_por_n <= 1'h0;
        i_osc_ready <= 1'h0;
        idle(4);
        chk(o_prdata, 32'h0000_0000);
        chk({o_pready, o_cpu_run, o_cold_start, o_mode, o_stack_level}, 7'h18);
        @(posedge i_clk);
        i_rst_n <= 1'h1;
        i_por_n <= 1'h1;
        idle(12);
        chk(o_cpu_run, 1'h0);
        @(posedge i_clk) i_osc_ready <= 1'h1;
        wait_run(100);
        apb(1'h0, 12'h004, 32'h0000_0000);
        chk(rd_val, 32'h0000_40C2);
        apb(1'h0, 12'h07C, 32'h0000_0000);
        chk(rd_val, 32'h0000_0000);
    endtask
    task automatic sc_conv;
        apb(1'h1, 12'h000, 32'h0000_0004);
        idle(4);
        chk({o_mode, o_sensor_supply_switch, o_adc_power}, 4'hF);
        apb(1'h1, 12'h000, 32'h0000_0008);
        idle(4);
        chk({o_mode, o_sensor_supply_switch, o_adc_power}, 4'h8);
        apb(1'h0, 12'h100, 32'h0000_0000);
        chk(slv_err, 1'h1);
    endtask
    initial begin
        i_clk = 1'h0;
        forever #2 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, i_por_n, i_osc_ready, i_tick_1hz, i_tick_16hz} = 5'h00;
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = 47'h0;
        err_count = 0;
        checks_done = 0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'h1;
        i_por_n <= 1'h1;
        sc_cold();
        sc_warm();
        sc_modes();
        sc_timers();
        sc_conv();
        sc_reset();
        close_out();
    end
endmodule // ipms_sequencer_tb
`default_nettype wire
